// File: hdl/adcc_cfg.svh
// Register map, field positions, reset values and divider codes of the converter control.
// Included by the package user files; holds only definitions.
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// Byte addresses on the Avalon-MM slave
`define ADCC_OFF_RES_LOW 5'h00
`define ADCC_OFF_RES_HIGH 5'h04
`define ADCC_OFF_CTRL 5'h08
`define ADCC_OFF_CLKSEL 5'h0C
`define ADCC_OFF_IRQ_STAT 5'h10
`define ADCC_OFF_IRQ_MASK 5'h14

// Control register fields
`define ADCC_CTRL_START 7
`define ADCC_CTRL_PEND 6
`define ADCC_CTRL_PIN_HI 5
`define ADCC_CTRL_PIN_LO 2
`define ADCC_CTRL_CHAN_HI 1
`define ADCC_CTRL_CHAN_LO 0
`define ADCC_CTRL_RST 8'h40

// Clock select register fields
`define ADCC_CLKSEL_TEST 7
`define ADCC_CLKSEL_PWROFF 6
`define ADCC_CLKSEL_DIV_HI 2
`define ADCC_CLKSEL_DIV_LO 0
`define ADCC_CLKSEL_RST 8'h80

// Interrupt status and mask: bit 0 is conversion complete
`define ADCC_IRQ_DONE 0

// Converter clock divider codes
`define ADCC_DIV2 3'h0
`define ADCC_DIV8 3'h1
`define ADCC_DIV32 3'h2
`define ADCC_DIV1 3'h4
`define ADCC_DIV4 3'h5
`define ADCC_DIV16 3'h6

// Result width and number of analog inputs
`define ADCC_RES_W 12
`define ADCC_NUM_CH 4

`endif

// File: hdl/adcc_pkg.sv
// Types shared by the converter control and its successive-approximation sequencer.
// Assumes adcc_cfg.svh is on the include path.
`include "adcc_cfg.svh"

package adcc_pkg;
    typedef logic [`ADCC_RES_W-1:0] adcc_result_t;
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_TRIAL} adcc_sar_state_t;
endpackage

// File: hdl/adcc_sar.sv
// Successive-approximation sequencer: one sample step, then twelve bit trials.
// Assumes a comparator on the same clock, valid in the cycle of each converter tick.
`timescale 1ns/1ps
`include "adcc_cfg.svh"

module adcc_sar (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Control
    input wire logic hold_i,
    input wire logic go_i,
    input wire logic tick_i,
    input wire logic comparator_i,
    // Status and result
    output logic busy_o,
    output logic done_o,
    output logic sample_o,
    output adcc_pkg::adcc_result_t dac_code_o,
    output adcc_pkg::adcc_result_t result_o
);
    import adcc_pkg::*;

    adcc_sar_state_t state_reg;
    logic [3:0] idx_reg;
    adcc_result_t kept;
    adcc_result_t one_hot;

    assign one_hot = adcc_result_t'(1) << idx_reg;
    // Comparator high means the input lies above the trial code
    assign kept = comparator_i ? dac_code_o : (dac_code_o & ~one_hot);

    always_ff @(posedge clock_i) begin
        if (srst_i || hold_i) begin
            state_reg <= SAR_IDLE;
            idx_reg <= 4'hB;
            dac_code_o <= '0;
            busy_o <= 1'b0;
            sample_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_reg)
                SAR_IDLE: begin
                    if (go_i) begin
                        state_reg <= SAR_SAMPLE;
                        busy_o <= 1'b1;
                        sample_o <= 1'b1;
                    end
                end
                SAR_SAMPLE: begin
                    if (tick_i) begin
                        state_reg <= SAR_TRIAL;
                        sample_o <= 1'b0;
                        idx_reg <= 4'hB;
                        dac_code_o <= 12'h800;
                    end
                end
                SAR_TRIAL: begin
                    if (tick_i) begin
                        if (idx_reg == 4'h0) begin
                            result_o <= kept;
                            done_o <= 1'b1;
                            busy_o <= 1'b0;
                            state_reg <= SAR_IDLE;
                        end else begin
                            dac_code_o <= kept | (one_hot >> 1);
                            idx_reg <= idx_reg - 4'h1;
                        end
                    end
                end
                default: state_reg <= SAR_IDLE;
            endcase
        end
    end
endmodule

// File: hdl/adcc_top.sv
// Converter control: Avalon-MM registers, start sequencing, clock divider, interrupt.
// Assumes an external analog core with mux, sample/hold, DAC and comparator on clock_i.
//
// Functional notes
// - Four analog inputs feed one converter giving a 12-bit result.
// - High result byte holds result bits 11 to 4.
// - Low result byte holds bits 3 to 0 on top; low nibble reads zero.
// - Both result bytes are read-only; contents undefined after reset.
// - Two-bit channel field routes exactly one input to the converter.
// - One shared converter: conversions run strictly one after another.
// - Start bit 0-1-0 starts; start held high resets converter, pending forced 1.
// - Each pin bit: 0 keeps digital I/O, 1 makes it analog input.
// - All four pin bits zero powers the converter down.
// - Control resets to start 0, pending 1, fields 0; pending read-only.
// - Conversion end clears pending and sets the interrupt request flag.
// - Three-bit divider code selects /2,/8,/32,/1,/4,/16 of the system clock.
// - Separate power-off bit in clock select switches the converter off.
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`include "adcc_cfg.svh"

module adcc_top (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Interrupt
    output logic irq_o,
    // Analog core
    input wire logic comparator_i,
    output logic [1:0] channel_select_o,
    output logic [3:0] pin_analog_o,
    output logic converter_enable_o,
    output logic converter_reset_o,
    output logic sample_o,
    output adcc_pkg::adcc_result_t dac_code_o
);
    import adcc_pkg::*;

    // Bus side
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic req;
    logic wr_lane0;

    // Control register
    logic start_reg;
    logic start_prev_reg;
    logic pending_reg;
    logic [3:0] pin_sel_reg;
    logic [1:0] chan_reg;

    // Clock select register
    logic test_reg;
    logic power_off_reg;
    logic [2:0] div_reg;

    // Interrupt
    logic irq_stat_reg;
    logic irq_mask_reg;
    logic irq_reg;

    // Converter timing and outputs
    logic [5:0] div_cnt_reg;
    logic [5:0] ratio;
    logic tick_reg;
    logic enable_reg;
    logic creset_reg;
    logic [1:0] chan_out_reg;
    logic [3:0] pin_out_reg;
    logic hold;
    logic go;
    logic sar_busy;
    logic sar_done;
    adcc_result_t sar_result;

    assign req = avs_read_i | avs_write_i;
    // A write takes effect only on the edge that completes it
    assign wr_lane0 = avs_write_i & ~wait_reg & avs_byteenable_i[0];

    // One wait state: data is captured on the first edge, answered on the next
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            wait_reg <= 1'b1;
        end else if (req && wait_reg) begin
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= 1'b1;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (avs_address_i == `ADCC_OFF_RES_LOW) begin
            rdata_next[7:4] = sar_result[3:0];
        end else if (avs_address_i == `ADCC_OFF_RES_HIGH) begin
            rdata_next[7:0] = sar_result[11:4];
        end else if (avs_address_i == `ADCC_OFF_CTRL) begin
            rdata_next[`ADCC_CTRL_START] = start_reg;
            rdata_next[`ADCC_CTRL_PEND] = pending_reg;
            rdata_next[`ADCC_CTRL_PIN_HI:`ADCC_CTRL_PIN_LO] = pin_sel_reg;
            rdata_next[`ADCC_CTRL_CHAN_HI:`ADCC_CTRL_CHAN_LO] = chan_reg;
        end else if (avs_address_i == `ADCC_OFF_CLKSEL) begin
            rdata_next[`ADCC_CLKSEL_TEST] = test_reg;
            rdata_next[`ADCC_CLKSEL_PWROFF] = power_off_reg;
            rdata_next[`ADCC_CLKSEL_DIV_HI:`ADCC_CLKSEL_DIV_LO] = div_reg;
        end else if (avs_address_i == `ADCC_OFF_IRQ_STAT) begin
            rdata_next[`ADCC_IRQ_DONE] = irq_stat_reg;
        end else if (avs_address_i == `ADCC_OFF_IRQ_MASK) begin
            rdata_next[`ADCC_IRQ_DONE] = irq_mask_reg;
        end else begin
            rdata_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read_i && wait_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    // Control register: pending is not writable
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            start_reg <= 1'b0;
            pin_sel_reg <= 4'h0;
            chan_reg <= 2'h0;
        end else if (wr_lane0 && avs_address_i == `ADCC_OFF_CTRL) begin
            start_reg <= avs_writedata_i[`ADCC_CTRL_START];
            pin_sel_reg <= avs_writedata_i[`ADCC_CTRL_PIN_HI:`ADCC_CTRL_PIN_LO];
            chan_reg <= avs_writedata_i[`ADCC_CTRL_CHAN_HI:`ADCC_CTRL_CHAN_LO];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            test_reg <= 1'b1;
            power_off_reg <= 1'b0;
            div_reg <= `ADCC_DIV2;
        end else if (wr_lane0 && avs_address_i == `ADCC_OFF_CLKSEL) begin
            test_reg <= avs_writedata_i[`ADCC_CLKSEL_TEST];
            power_off_reg <= avs_writedata_i[`ADCC_CLKSEL_PWROFF];
            div_reg <= avs_writedata_i[`ADCC_CLKSEL_DIV_HI:`ADCC_CLKSEL_DIV_LO];
        end
    end

    // Start falling edge launches a conversion; high level keeps the core in reset
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            start_prev_reg <= 1'b0;
        end else begin
            start_prev_reg <= start_reg;
        end
    end

    assign hold = start_reg | ~enable_reg;
    assign go = start_prev_reg & ~start_reg & enable_reg;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pending_reg <= 1'b1;
        end else if (start_reg) begin
            pending_reg <= 1'b1;
        end else if (sar_done) begin
            pending_reg <= 1'b0;
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            irq_stat_reg <= 1'b0;
        end else if (sar_done) begin
            irq_stat_reg <= 1'b1;
        end else if (wr_lane0 && avs_address_i == `ADCC_OFF_IRQ_STAT
                     && avs_writedata_i[`ADCC_IRQ_DONE]) begin
            irq_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            irq_mask_reg <= 1'b0;
        end else if (wr_lane0 && avs_address_i == `ADCC_OFF_IRQ_MASK) begin
            irq_mask_reg <= avs_writedata_i[`ADCC_IRQ_DONE];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_stat_reg & irq_mask_reg;
        end
    end

    // Undefined codes fall back to /2 rather than stopping the converter
    always_comb begin
        case (div_reg)
            `ADCC_DIV2: ratio = 6'h02;
            `ADCC_DIV8: ratio = 6'h08;
            `ADCC_DIV32: ratio = 6'h20;
            `ADCC_DIV1: ratio = 6'h01;
            `ADCC_DIV4: ratio = 6'h04;
            `ADCC_DIV16: ratio = 6'h10;
            default: ratio = 6'h02;
        endcase
    end

    // Divider only runs during a conversion so each step gets a full period
    always_ff @(posedge clock_i) begin
        if (srst_i || !sar_busy || go) begin
            div_cnt_reg <= 6'h00;
            tick_reg <= 1'b0;
        end else if (div_cnt_reg >= ratio - 6'h01) begin
            div_cnt_reg <= 6'h00;
            tick_reg <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
            tick_reg <= 1'b0;
        end
    end

    // Converter power and analog routing
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            enable_reg <= 1'b0;
            creset_reg <= 1'b1;
            chan_out_reg <= 2'h0;
            pin_out_reg <= 4'h0;
        end else begin
            enable_reg <= ~power_off_reg & (|pin_sel_reg);
            creset_reg <= hold;
            chan_out_reg <= chan_reg;
            pin_out_reg <= pin_sel_reg;
        end
    end

    // A single sequencer instance keeps conversions strictly serial
    adcc_sar u_sar (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .hold_i(hold),
        .go_i(go),
        .tick_i(tick_reg),
        .comparator_i(comparator_i),
        .busy_o(sar_busy),
        .done_o(sar_done),
        .sample_o(sample_o),
        .dac_code_o(dac_code_o),
        .result_o(sar_result)
    );

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o = rdata_reg;
    assign irq_o = irq_reg;
    assign channel_select_o = chan_out_reg;
    assign pin_analog_o = pin_out_reg;
    assign converter_enable_o = enable_reg;
    assign converter_reset_o = creset_reg;

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    property p_low_nibble;
        (avs_read_i && !avs_waitrequest_o && avs_address_i == `ADCC_OFF_RES_LOW)
            |-> avs_readdata_o[3:0] == 4'h0 && avs_readdata_o[31:8] == 24'h000000;
    endproperty
    a_low_nibble: assert property (p_low_nibble) else $error("low nibble not zero");

    property p_high_map;
        (avs_read_i && avs_waitrequest_o && avs_address_i == `ADCC_OFF_RES_HIGH)
            |=> avs_readdata_o[7:0] == $past(sar_result[11:4]);
    endproperty
    a_high_map: assert property (p_high_map) else $error("high byte mismatch");

    property p_chan_route;
        (wr_lane0 && avs_address_i == `ADCC_OFF_CTRL)
            |=> ##1 channel_select_o == $past(avs_writedata_i[1:0], 2);
    endproperty
    a_chan_route: assert property (p_chan_route) else $error("channel not routed");

    property p_pin_cfg;
        (wr_lane0 && avs_address_i == `ADCC_OFF_CTRL)
            |=> ##1 pin_analog_o == $past(avs_writedata_i[5:2], 2);
    endproperty
    a_pin_cfg: assert property (p_pin_cfg) else $error("pin config not applied");

    property p_power_down;
        (pin_sel_reg == 4'h0 || power_off_reg) |=> !converter_enable_o;
    endproperty
    a_power_down: assert property (p_power_down) else $error("converter still on");

    property p_start_hold;
        $rose(start_reg) |=> pending_reg && converter_reset_o && !sar_busy;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start hold failed");

    property p_done_flags;
        sar_done |=> !pending_reg && irq_stat_reg;
    endproperty
    a_done_flags: assert property (p_done_flags) else $error("end flags wrong");

    property p_result_first;
        $fell(pending_reg) |-> $past(sar_done) && $stable(sar_result);
    endproperty
    a_result_first: assert property (p_result_first) else $error("result late");

    property p_reset_vals;
        $fell(srst_i) |-> pending_reg && !start_reg && pin_sel_reg == 4'h0 && chan_reg == 2'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

    property p_div8;
        (tick_reg && div_reg == `ADCC_DIV8 && $stable(div_reg)) |=> !tick_reg [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong");

    property p_serial;
        go |-> !sar_busy ##1 sar_busy;
    endproperty
    a_serial: assert property (p_serial) else $error("overlapping conversion");

    property p_irq_out;
        (irq_stat_reg && irq_mask_reg) |=> irq_o;
    endproperty
    a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

    c_conv_done: cover property (go ##[1:800] sar_done);
    c_start_held: cover property (start_reg [*4]);
    c_irq: cover property ($rose(irq_o));
    c_clear_race: cover property (sar_done && wr_lane0 && avs_address_i == `ADCC_OFF_IRQ_STAT);
endmodule

// File: test/adcc_analog_model.sv
// Analog front end: four input levels, input mux, sample/hold and one comparator.
// Assumes the control drives mux select, sample and DAC code on the same clock.
`timescale 1ns/1ps

module adcc_analog_model (
    // Clock
    input wire logic clock_i,
    // From the converter control
    input wire logic [1:0] channel_select_i,
    input wire logic sample_i,
    input wire logic enable_i,
    input wire adcc_pkg::adcc_result_t dac_code_i,
    // One 12-bit level per input
    input wire logic [47:0] levels_i,
    // Comparator
    output logic comparator_o
);
    import adcc_pkg::*;
    adcc_result_t held_reg = '0;
    logic cmp;
    logic junk_reg = 1'b0;
    // Only the selected input reaches the single hold stage
    always_ff @(posedge clock_i) begin
        if (sample_i && enable_i) begin
            held_reg <= levels_i[channel_select_i*12 +: 12];
        end
        junk_reg <= ~junk_reg;
    end
    // Level sits half a step above its code, so either comparison reading gives the code
    assign cmp = {held_reg, 1'b1} > {dac_code_i, 1'b0};
    // Unpowered comparator gives no usable answer
    assign comparator_o = enable_i ? cmp : junk_reg;
endmodule

// File: test/adcc_top_tb_top.sv
// Self-checking bench of the converter control with an analog front end model.
// Assumes adcc_cfg.svh on the include path and a 100 MHz clock.
`timescale 1ns/1ps
`include "adcc_cfg.svh"

module adcc_top_tb_top;
    import adcc_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic irq_o;
    logic comparator_i;
    logic [1:0] channel_select_o;
    logic [3:0] pin_analog_o;
    logic converter_enable_o;
    logic converter_reset_o;
    logic sample_o;
    adcc_result_t dac_code_o;
    logic [47:0] levels = 48'h0;
    logic [15:0] rnd = 16'd93;
    logic [7:0] rx;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int exp_q[$];
    int t;
    int base;
    int codes[6] = '{4, 0, 5, 1, 6, 2};
    int ratios[6] = '{1, 2, 4, 8, 16, 32};

    adcc_top dut (.clock_i(clock_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .irq_o(irq_o), .comparator_i(comparator_i), .channel_select_o(channel_select_o),
        .pin_analog_o(pin_analog_o), .converter_enable_o(converter_enable_o),
        .converter_reset_o(converter_reset_o), .sample_o(sample_o), .dac_code_o(dac_code_o));

    adcc_analog_model analog (.clock_i(clock_i), .channel_select_i(channel_select_o),
        .sample_i(sample_o), .enable_i(converter_enable_o), .dac_code_i(dac_code_o),
        .levels_i(levels), .comparator_o(comparator_i));

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    // Hang guard, well above the longest expected run
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            end_of_test();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One Avalon transfer; a free cycle before each keeps release and request apart
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clock_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h0, d};
        do begin
            @(posedge clock_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        q = avs_readdata_o[7:0];
        check("bus answer", 1, n < 50);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdchk(input string nm, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, a, 8'h00, x);
        check(nm, e, x);
    endtask

    // Start pulse, wait for the level interrupt, check result bytes and clear
    task automatic convert(input int ch, input int code, input bit abort, output int n);
        int v;
        rnd = lfsr(rnd);
        v = rnd[11:0];
        exp_q.push_back(v);
        levels[ch*12 +: 12] <= v[11:0];
        wr(`ADCC_OFF_CLKSEL, code[7:0]);
        wr(`ADCC_OFF_CTRL, 8'h3C | ch[7:0]);
        // Routing outputs are registered copies of the control fields
        repeat (2) @(posedge clock_i);
        check("channel", ch, channel_select_o);
        check("pins", 4'hF, pin_analog_o);
        check("enable", 1, converter_enable_o);
        wr(`ADCC_OFF_CTRL, 8'hBC | ch[7:0]);
        rdchk("pending set", `ADCC_OFF_CTRL, 8'hFC | ch[7:0]);
        wr(`ADCC_OFF_CTRL, 8'h3C | ch[7:0]);
        repeat (2) @(posedge clock_i);
        check("sample", 1, sample_o);
        if (abort) begin
            repeat (20) @(posedge clock_i);
            wr(`ADCC_OFF_CTRL, 8'hBC | ch[7:0]);
            repeat (500) @(posedge clock_i);
            check("abort irq", 0, irq_o);
            check("abort reset", 1, converter_reset_o);
            rdchk("abort pending", `ADCC_OFF_CTRL, 8'hFC | ch[7:0]);
            wr(`ADCC_OFF_CTRL, 8'h3C | ch[7:0]);
        end
        n = 0;
        while (irq_o !== 1'b1 && n < 2000) begin
            @(posedge clock_i);
            n++;
        end
        check("irq", 1, irq_o);
        rdchk("pending clear", `ADCC_OFF_CTRL, 8'h3C | ch[7:0]);
        v = exp_q.pop_front();
        rdchk("result high", `ADCC_OFF_RES_HIGH, v[11:4]);
        rdchk("result low", `ADCC_OFF_RES_LOW, {v[3:0], 4'h0});
        wr(`ADCC_OFF_RES_HIGH, ~v[11:4]);
        rdchk("result ro", `ADCC_OFF_RES_HIGH, v[11:4]);
        rdchk("status", `ADCC_OFF_IRQ_STAT, 8'h01);
        wr(`ADCC_OFF_IRQ_STAT, 8'h01);
        repeat (2) @(posedge clock_i);
        check("irq cleared", 0, irq_o);
    endtask

    initial begin
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        rdchk("ctrl reset", `ADCC_OFF_CTRL, 8'h40);
        rdchk("clksel reset", `ADCC_OFF_CLKSEL, 8'h80);
        rdchk("status reset", `ADCC_OFF_IRQ_STAT, 8'h00);
        rdchk("mask reset", `ADCC_OFF_IRQ_MASK, 8'h00);
        rdchk("unmapped", 5'h18, 8'h00);
        wr(`ADCC_OFF_CTRL, 8'h00);
        rdchk("pending ro", `ADCC_OFF_CTRL, 8'h40);
        check("pins off", 0, converter_enable_o);
        // Start sequence with every pin digital must not launch anything
        wr(`ADCC_OFF_CTRL, 8'h81);
        wr(`ADCC_OFF_CTRL, 8'h01);
        repeat (100) @(posedge clock_i);
        rdchk("no conversion pins", `ADCC_OFF_IRQ_STAT, 8'h00);
        wr(`ADCC_OFF_CLKSEL, 8'h40);
        wr(`ADCC_OFF_CTRL, 8'hBD);
        wr(`ADCC_OFF_CTRL, 8'h3D);
        repeat (2) @(posedge clock_i);
        check("power bit", 0, converter_enable_o);
        repeat (100) @(posedge clock_i);
        rdchk("no conversion", `ADCC_OFF_IRQ_STAT, 8'h00);
        wr(`ADCC_OFF_IRQ_MASK, 8'h01);
        for (int i = 0; i < 6; i++) begin
            convert(i % 4, codes[i], 1'b0, t);
            if (i == 0) begin
                base = t;
            end
            check("duration", 1, (t - base - 13 * (ratios[i] - 1)) <= ratios[i]
                && (base + 13 * (ratios[i] - 1) - t) <= ratios[i]);
        end
        convert(3, 2, 1'b1, t);
        // Masked event still sets status; unmasking raises the line
        wr(`ADCC_OFF_IRQ_MASK, 8'h00);
        wr(`ADCC_OFF_CTRL, 8'hBE);
        wr(`ADCC_OFF_CTRL, 8'h3E);
        // Divider is still at /32 here, so a conversion needs over 400 cycles
        repeat (500) @(posedge clock_i);
        check("masked irq", 0, irq_o);
        rdchk("masked status", `ADCC_OFF_IRQ_STAT, 8'h01);
        wr(`ADCC_OFF_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clock_i);
        check("unmasked irq", 1, irq_o);
        end_of_test();
    end
endmodule
